//--- hw/emb_defs.svh
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH

// Cycles that a pin input spends in its synchroniser
`define EMB_SYNC_LAT     2
// Address latch strobe width, in link clock cycles
`define EMB_ALE_CYC      2
// Address hold after the latch strobe closes
`define EMB_HOLD_CYC     1
// Address setup before the strobe in non-multiplexed cycles
`define EMB_SETUP_CYC    1
// Idle gap after a strobe before the next access
`define EMB_RECOVER_CYC  1
// Reset value of the multiplexed address/data output word
`define EMB_PAD_RST      16'h0000

`endif

//--- hw/emb_pkg.sv
package emb_pkg;

  // Bus sequencer states on the link clock
  typedef enum logic [2:0] {
    EMB_IDLE,
    EMB_ALE,
    EMB_HOLD,
    EMB_SETUP,
    EMB_STRB,
    EMB_DONE
  } emb_state_e;

  // Run-time configuration, captured with every request
  typedef struct packed {
    logic            busEn;       // Pins serve the bus, else GPIO
    logic            wide16;      // 16-bit data path, else 8-bit
    logic            muxMode;     // Address and data share pins
    logic            alePolHigh;  // Latch strobe active high
    logic            byteEnMode;  // Byte strobes act as enables, 16-bit only
    logic            burstEn;     // Burst device pins in use
    logic            pageEn;      // Page mode, non-mux only
    logic [3:0][3:0] rdWait;      // Read wait states per region
    logic [3:0][3:0] wrWait;      // Write wait states per region
  } emb_cfg_s;

  // One access as handed across the clock crossing
  typedef struct packed {
    emb_cfg_s    cfg;
    logic [1:0]  region;
    logic [23:0] addr;
    logic        write;
    logic [1:0]  byteEn;
    logic [15:0] wdata;
  } emb_cmd_s;

  // Shared address/data pins, output side
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } emb_pad_s;

endpackage : emb_pkg

//--- hw/emb_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser; only the second stage leaves the module
module emb_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             en,
  // Data
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] stage_q;  // Metastable stage
  logic [WIDTH-1:0] stage_d;
  logic [WIDTH-1:0] sync_q;   // Settled stage
  logic [WIDTH-1:0] sync_d;

  // Next values: a plain shift
  always_comb begin
    stage_d = async;
    sync_d  = stage_q;
  end

  // Registers, frozen while the enable is low
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage_q <= '0;
      sync_q  <= '0;
    end else if (en) begin
      stage_q <= stage_d;
      sync_q  <= sync_d;
    end
  end

  assign sync = sync_q;

endmodule : emb_sync

//--- hw/emb_ext_mem_bus.sv
`timescale 1ns/10ps
`include "emb_defs.svh"
module emb_ext_mem_bus
  import emb_pkg::*;
(
  // System clock domain
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  // Configuration
  input  wire emb_cfg_s    cfg,
  input  wire logic [15:0] gpioOut,
  input  wire logic [15:0] gpioOe,
  output logic      [15:0] gpioIn,
  // Request
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic [1:0]  reqRegion,
  input  wire logic [23:0] reqAddr,
  input  wire logic        reqWrite,
  input  wire logic [1:0]  reqByteEn,
  input  wire logic [15:0] reqWdata,
  // Answer
  output logic             rspValid,
  output logic      [15:0] rspRdata,
  // Link clock domain
  input  wire logic        linkClk,
  // External bus pins
  output logic      [3:0]  regionSelectN,
  output logic             readStrobeN,
  output logic             lowByteWriteStrobeN,
  output logic             highByteWriteStrobeN,
  output logic             writeEnableN,
  output logic             addrLatchStrobe,
  output logic             burstAddrAdvanceN,
  output logic             burstBusClock,
  input  wire logic        burstWaitN,
  output logic      [23:0] extAddr,
  output logic      [15:0] adOut,
  output logic      [15:0] adOe,
  input  wire logic [15:0] adIn
);

  // ---------------- System domain ----------------
  logic        reqReady_q, reqReady_d;  // Crossing is free
  logic        reqTog_q, reqTog_d;      // Flips once per request
  emb_cmd_s    cmdHold_q, cmdHold_d;    // Stable while in flight
  logic        ackSeen_q, ackSeen_d;    // Last acknowledge seen
  logic        rspValid_q, rspValid_d;  // One-cycle answer pulse
  logic [15:0] rspRdata_q, rspRdata_d;  // Read data to the user
  logic        ackSync;                 // Acknowledge toggle, synced

  // ---------------- Link domain ----------------
  emb_state_e  state_q, state_d;        // Bus sequencer
  logic [4:0]  cnt_q, cnt_d;            // Phase length counter
  emb_cmd_s    cmd_q, cmd_d;            // Access being run
  logic        reqSeen_q, reqSeen_d;    // Last request toggle seen
  logic        ackTog_q, ackTog_d;      // Flips once per answer
  logic [15:0] rspHold_q, rspHold_d;    // Answer data, held
  logic        pageOpen_q, pageOpen_d;  // Select left low for page
  logic [1:0]  pageReg_q, pageReg_d;    // Region of the open page
  logic [3:0]  selN_q, selN_d;
  logic        rdN_q, rdN_d;
  logic        wrLN_q, wrLN_d;
  logic        wrHN_q, wrHN_d;
  logic        weN_q, weN_d;
  logic        ale_q, ale_d;
  logic        baaN_q, baaN_d;
  logic        bclk_q, bclk_d;
  logic [23:0] addr_q, addr_d;
  emb_pad_s    pad_q, pad_d;
  logic        reqSync;                 // Request toggle, synced
  logic        waitSyncN;               // Wait input, synced, active low
  logic [15:0] adInSync;                // Shared pins, synced
  logic [32:0] gpioSync;                // {busEn, oe, out}, synced

  // Request toggle into the link domain
  emb_sync #(.WIDTH(1)) u_reqSync (
    .clk   (linkClk),
    .rstN  (nrst),
    .en    (1'b1),
    .async (reqTog_q),
    .sync  (reqSync)
  );

  // Acknowledge toggle back to the system domain
  emb_sync #(.WIDTH(1)) u_ackSync (
    .clk   (sys_clk),
    .rstN  (nrst),
    .en    (clkEn),
    .async (ackTog_q),
    .sync  (ackSync)
  );

  // Static GPIO settings; skew between bits is harmless here
  emb_sync #(.WIDTH(33)) u_gpioSync (
    .clk   (linkClk),
    .rstN  (nrst),
    .en    (1'b1),
    .async ({cfg.busEn, gpioOe, gpioOut}),
    .sync  (gpioSync)
  );

  // Pin readback for GPIO use, in the system domain
  emb_sync #(.WIDTH(16)) u_gpioInSync (
    .clk   (sys_clk),
    .rstN  (nrst),
    .en    (clkEn),
    .async (adIn),
    .sync  (gpioIn)
  );

  // Read data pins into the link domain
  emb_sync #(.WIDTH(16)) u_adSync (
    .clk   (linkClk),
    .rstN  (nrst),
    .en    (1'b1),
    .async (adIn),
    .sync  (adInSync)
  );

  // Wait input; reset reads as waiting, harmless as no strobe runs then
  emb_sync #(.WIDTH(1)) u_waitSync (
    .clk   (linkClk),
    .rstN  (nrst),
    .en    (1'b1),
    .async (burstWaitN),
    .sync  (waitSyncN)
  );

  // System side: take a request, hand it over, return the answer
  always_comb begin
    reqReady_d = reqReady_q;
    reqTog_d   = reqTog_q;
    cmdHold_d  = cmdHold_q;
    ackSeen_d  = ackSeen_q;
    rspValid_d = 1'b0;
    rspRdata_d = rspRdata_q;
    // Answer arrived: pulse it and free the crossing
    if (ackSync != ackSeen_q) begin
      ackSeen_d  = ackSync;
      rspValid_d = 1'b1;
      rspRdata_d = rspHold_q;
      reqReady_d = 1'b1;
    end
    // Configuration travels with the request, so it is coherent
    if (reqValid && reqReady_q) begin
      cmdHold_d = '{cfg: cfg, region: reqRegion, addr: reqAddr,
                    write: reqWrite, byteEn: reqByteEn,
                    wdata: reqWdata};
      reqTog_d   = ~reqTog_q;
      reqReady_d = 1'b0;
    end
  end

  // System side registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reqReady_q <= 1'b1;
      reqTog_q   <= 1'b0;
      cmdHold_q  <= '0;
      ackSeen_q  <= 1'b0;
      rspValid_q <= 1'b0;
      rspRdata_q <= 16'h0000;
    end else if (clkEn) begin
      reqReady_q <= reqReady_d;
      reqTog_q   <= reqTog_d;
      cmdHold_q  <= cmdHold_d;
      ackSeen_q  <= ackSeen_d;
      rspValid_q <= rspValid_d;
      rspRdata_q <= rspRdata_d;
    end
  end

  // Link side: sequence one access, then drive the pins from it
  always_comb begin
    logic        busy;
    logic        addrPh;
    logic        strb;
    logic [3:0]  waits;
    state_d    = state_q;
    cnt_d      = cnt_q;
    cmd_d      = cmd_q;
    reqSeen_d  = reqSeen_q;
    ackTog_d   = ackTog_q;
    rspHold_d  = rspHold_q;
    pageOpen_d = pageOpen_q;
    pageReg_d  = pageReg_q;
    busy       = 1'b0;
    addrPh     = 1'b0;
    strb       = 1'b0;
    waits      = 4'h0;
    case (state_q)
      EMB_IDLE: begin
        if (reqSync != reqSeen_q) begin
          reqSeen_d = reqSync;
          cmd_d     = cmdHold_q;
          if (!cmdHold_q.cfg.busEn) begin
            // Bus disabled: answer at once, no pin activity
            rspHold_d = 16'h0000;
            ackTog_d  = ~ackTog_q;
          end else if (cmdHold_q.cfg.muxMode) begin
            pageOpen_d = 1'b0;
            state_d    = EMB_ALE;
            cnt_d      = 5'(`EMB_ALE_CYC - 1);
          end else if (pageOpen_q && cmdHold_q.cfg.pageEn &&
                       pageReg_q == cmdHold_q.region) begin
            // Page hit skips the address setup phase
            waits   = cmdHold_q.write ? cmdHold_q.cfg.wrWait[cmdHold_q.region]
                                      : cmdHold_q.cfg.rdWait[cmdHold_q.region];
            state_d = EMB_STRB;
            cnt_d   = {1'b0, waits} + 5'(`EMB_SYNC_LAT);
          end else begin
            pageOpen_d = 1'b0;
            state_d    = EMB_SETUP;
            cnt_d      = 5'(`EMB_SETUP_CYC - 1);
          end
        end
      end
      EMB_ALE: begin
        if (cnt_q == 5'd0) begin
          state_d = EMB_HOLD;
          cnt_d   = 5'(`EMB_HOLD_CYC - 1);
        end else begin
          cnt_d = cnt_q - 5'd1;
        end
      end
      EMB_HOLD, EMB_SETUP: begin
        if (cnt_q == 5'd0) begin
          // Strobe covers the wait states plus the sampling lag
          waits   = cmd_q.write ? cmd_q.cfg.wrWait[cmd_q.region]
                                : cmd_q.cfg.rdWait[cmd_q.region];
          state_d = EMB_STRB;
          cnt_d   = {1'b0, waits} + 5'(`EMB_SYNC_LAT);
        end else begin
          cnt_d = cnt_q - 5'd1;
        end
      end
      EMB_STRB: begin
        if (cnt_q != 5'd0) begin
          cnt_d = cnt_q - 5'd1;
        end else if (cmd_q.cfg.burstEn && !waitSyncN) begin
          // Burst device asks for more time; hold the strobe
          state_d = EMB_STRB;
        end else begin
          // Synced pins lag by two cycles, still inside the strobe
          rspHold_d  = cmd_q.cfg.wide16 ? adInSync
                                        : {8'h00, adInSync[7:0]};
          ackTog_d   = ~ackTog_q;
          pageOpen_d = cmd_q.cfg.pageEn && !cmd_q.cfg.muxMode;
          pageReg_d  = cmd_q.region;
          state_d    = EMB_DONE;
          cnt_d      = 5'(`EMB_RECOVER_CYC - 1);
        end
      end
      EMB_DONE: begin
        if (cnt_q == 5'd0) begin
          state_d = EMB_IDLE;
        end else begin
          cnt_d = cnt_q - 5'd1;
        end
      end
      default: begin
        state_d = EMB_IDLE;
      end
    endcase

    // Pin values follow the state being entered
    busy   = state_d != EMB_IDLE;
    addrPh = state_d == EMB_ALE || state_d == EMB_HOLD;
    strb   = state_d == EMB_STRB;

    // Chip select: whole access, or held open by page mode
    selN_d = 4'hf;
    if (busy) begin
      selN_d[cmd_d.region] = 1'b0;
    end else if (pageOpen_d) begin
      selN_d[pageReg_d] = 1'b0;
    end

    // Latch strobe, active level from the configuration
    ale_d = (state_d == EMB_ALE) ~^ cmd_d.cfg.alePolHigh;

    // One read strobe for both bytes
    rdN_d = !(strb && !cmd_d.write);

    // Byte strobes, or byte enables with a common write enable
    if (cmd_d.cfg.byteEnMode && cmd_d.cfg.wide16) begin
      wrLN_d = !(strb && cmd_d.byteEn[0]);
      wrHN_d = !(strb && cmd_d.byteEn[1]);
      weN_d  = !(strb && cmd_d.write);
    end else begin
      wrLN_d = !(strb && cmd_d.write &&
                 (cmd_d.byteEn[0] || !cmd_d.cfg.wide16));
      wrHN_d = !(strb && cmd_d.write && cmd_d.cfg.wide16 &&
                 cmd_d.byteEn[1]);
      weN_d  = 1'b1;
    end

    // Burst pins run only for non-multiplexed burst devices
    baaN_d = !(cmd_d.cfg.burstEn && !cmd_d.cfg.muxMode &&
               state_d == EMB_SETUP);
    bclk_d = (busy && cmd_d.cfg.burstEn && !cmd_d.cfg.muxMode) ?
             ~bclk_q : 1'b0;

    // Dedicated address; top byte is the high address port
    addr_d = busy ? cmd_d.addr : addr_q;

    // Shared pins: GPIO, address phase, write data, or released
    if (!gpioSync[32]) begin
      pad_d.out = gpioSync[15:0];
      pad_d.oe  = gpioSync[31:16];
    end else if (addrPh) begin
      // Low and mid address bytes share the data pins
      pad_d.out = cmd_d.addr[15:0];
      pad_d.oe  = 16'hffff;
    end else if (busy && cmd_d.write) begin
      // Mid port carries zeros as data in 8-bit mode
      pad_d.out = cmd_d.cfg.wide16 ? cmd_d.wdata
                                   : {8'h00, cmd_d.wdata[7:0]};
      pad_d.oe  = 16'hffff;
    end else begin
      pad_d.out = pad_q.out;
      pad_d.oe  = 16'h0000;
    end
  end

  // Link side registers
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= EMB_IDLE;
      cnt_q      <= 5'd0;
      cmd_q      <= '0;
      reqSeen_q  <= 1'b0;
      ackTog_q   <= 1'b0;
      rspHold_q  <= 16'h0000;
      pageOpen_q <= 1'b0;
      pageReg_q  <= 2'd0;
      selN_q     <= 4'hf;
      rdN_q      <= 1'b1;
      wrLN_q     <= 1'b1;
      wrHN_q     <= 1'b1;
      weN_q      <= 1'b1;
      ale_q      <= 1'b1;
      baaN_q     <= 1'b1;
      bclk_q     <= 1'b0;
      addr_q     <= 24'h00_0000;
      pad_q      <= '{out: `EMB_PAD_RST, oe: 16'h0000};
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      cmd_q      <= cmd_d;
      reqSeen_q  <= reqSeen_d;
      ackTog_q   <= ackTog_d;
      rspHold_q  <= rspHold_d;
      pageOpen_q <= pageOpen_d;
      pageReg_q  <= pageReg_d;
      selN_q     <= selN_d;
      rdN_q      <= rdN_d;
      wrLN_q     <= wrLN_d;
      wrHN_q     <= wrHN_d;
      weN_q      <= weN_d;
      ale_q      <= ale_d;
      baaN_q     <= baaN_d;
      bclk_q     <= bclk_d;
      addr_q     <= addr_d;
      pad_q      <= pad_d;
    end
  end

  // Outputs straight from registers
  assign reqReady             = reqReady_q;
  assign rspValid             = rspValid_q;
  assign rspRdata             = rspRdata_q;
  assign regionSelectN        = selN_q;
  assign readStrobeN          = rdN_q;
  assign lowByteWriteStrobeN  = wrLN_q;
  assign highByteWriteStrobeN = wrHN_q;
  assign writeEnableN         = weN_q;
  assign addrLatchStrobe      = ale_q;
  assign burstAddrAdvanceN    = baaN_q;
  assign burstBusClock        = bclk_q;
  assign extAddr              = addr_q;
  assign adOut                = pad_q.out;
  assign adOe                 = pad_q.oe;

endmodule : emb_ext_mem_bus

//--- tb/emb_chk.sv
`timescale 1ns/10ps
// Watches the controller ports on both clocks
module emb_chk
  import emb_pkg::*;
(
  // System side
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        clkEn,
  input wire emb_cfg_s    cfg,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire logic        rspValid,
  // Link side
  input wire logic        linkClk,
  input wire logic [3:0]  regionSelectN,
  input wire logic        readStrobeN,
  input wire logic        lowByteWriteStrobeN,
  input wire logic        highByteWriteStrobeN,
  input wire logic        addrLatchStrobe,
  input wire logic        burstBusClock,
  input wire logic [15:0] adOut,
  input wire logic [15:0] adOe
);
  // Any data strobe active
  wire strb = !readStrobeN || !lowByteWriteStrobeN || !highByteWriteStrobeN;

  // Latch phase, then its hold cycle
  sequence s_addr;
    addrLatchStrobe == cfg.alePolHigh ##1 addrLatchStrobe != cfg.alePolHigh;
  endsequence

  property p_sel_one;
    @(posedge linkClk) disable iff (!nrst) $onehot0(~regionSelectN);
  endproperty
  a_sel_one: assert property (p_sel_one)
    else $error("more than one select low");
  property p_strb_sel;
    @(posedge linkClk) disable iff (!nrst) strb |-> regionSelectN != 4'hf;
  endproperty
  a_strb_sel: assert property (p_strb_sel)
    else $error("strobe without select");
  // Strobe follows the hold cycle; cfg is only changed while idle
  property p_ale_first;
    @(posedge linkClk) disable iff (!nrst)
      cfg.busEn && cfg.muxMode ##0 s_addr |=> strb;
  endproperty
  a_ale_first: assert property (p_ale_first)
    else $error("strobe not after latch phase");
  property p_mux8_zero;
    @(posedge linkClk) disable iff (!nrst)
      cfg.muxMode && !cfg.wide16 && !lowByteWriteStrobeN
        |-> adOut[15:8] == 8'h00;
  endproperty
  a_mux8_zero: assert property (p_mux8_zero)
    else $error("mid port not zero in write");
  property p_no_high8;
    @(posedge linkClk) disable iff (!nrst)
      !cfg.wide16 |-> highByteWriteStrobeN;
  endproperty
  a_no_high8: assert property (p_no_high8)
    else $error("high strobe in 8-bit mode");
  property p_rd_rel;
    @(posedge linkClk) disable iff (!nrst)
      cfg.muxMode && !readStrobeN |-> adOe[7:0] == 8'h00;
  endproperty
  a_rd_rel: assert property (p_rd_rel)
    else $error("low port driven during read");
  property p_gpio;
    @(posedge linkClk) disable iff (!nrst)
      !cfg.busEn |-> regionSelectN == 4'hf && !strb;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("bus activity with bus off");
  property p_bclk;
    @(posedge linkClk) disable iff (!nrst) !cfg.burstEn |-> !burstBusClock;
  endproperty
  a_bclk: assert property (p_bclk)
    else $error("bus clock without burst");
  property p_take;
    @(posedge sys_clk) disable iff (!nrst)
      clkEn && reqValid && reqReady |=> !reqReady;
  endproperty
  a_take: assert property (p_take)
    else $error("ready after take");
  property p_rsp;
    @(posedge sys_clk) disable iff (!nrst)
      rspValid |-> reqReady && !$past(reqReady);
  endproperty
  a_rsp: assert property (p_rsp)
    else $error("answer without pending take");
endmodule : emb_chk

bind emb_ext_mem_bus emb_chk u_chk (.sys_clk, .nrst, .clkEn, .cfg,
  .reqValid, .reqReady, .rspValid, .linkClk, .regionSelectN, .readStrobeN,
  .lowByteWriteStrobeN, .highByteWriteStrobeN, .addrLatchStrobe,
  .burstBusClock, .adOut, .adOe);

//--- tb/emb_mem_model.sv
`timescale 1ns/10ps
// Far side: static memory behind an address latch
module emb_mem_model (
  // Link clock and bus pins
  input wire logic        linkClk,
  input wire logic [3:0]  selN,
  input wire logic        rdN,
  input wire logic        wrLN,
  input wire logic        wrHN,
  input wire logic        weN,
  input wire logic        beMode,
  input wire logic        ale,
  input wire logic        alePol,
  input wire logic        mux,
  input wire logic [23:0] extAddr,
  input wire logic [15:0] adOut,
  input wire logic [15:0] adOe,
  input wire logic        holdWait,
  // Levels returned to the controller
  output logic      [15:0] adIn,
  output logic             burstWaitN
);
  logic [15:0] mem [16];        // Tiny store, low nibble index
  logic [15:0] latA;            // External latch contents
  logic [15:0] lastV = 16'h0000; // Last wire level
  logic [3:0]  idx;
  logic        drvOn;
  logic        wrOk;
  // Byte enables only write together with the common write enable
  assign wrOk = selN != 4'hf && (!beMode || !weN);
  assign idx = mux ? latA[3:0] : extAddr[3:0];
  assign drvOn = !rdN && selN != 4'hf;
  // Floating bits show the inverse of the last level
  assign adIn = (adOe & adOut) | (~adOe & (drvOn ? mem[idx] : ~lastV));
  assign burstWaitN = !holdWait;
  // Latch follows the pins while the strobe is active
  always @(posedge linkClk) begin
    lastV <= adIn;
    if (ale == alePol) latA <= adOut;
    if (!wrLN && wrOk) mem[idx][7:0] <= adOut[7:0];
    if (!wrHN && wrOk) mem[idx][15:8] <= adOut[15:8];
  end
endmodule : emb_mem_model

//--- tb/tb.sv
`timescale 1ns/10ps
// Self-checking bench for the external memory bus
module tb;
  import emb_pkg::*;
  logic sys_clk = 1'b0;
  logic linkClk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  emb_cfg_s cfg = '0;
  logic [15:0] gpioOut = 16'h0000, gpioOe = 16'h0000, gpioIn;
  logic reqValid = 1'b0, reqReady, reqWrite = 1'b0, rspValid;
  logic [1:0] reqRegion = 2'b00, reqByteEn = 2'b00;
  logic [23:0] reqAddr = 24'h00_0000, extAddr;
  logic [15:0] reqWdata = 16'h0000, rspRdata, adOut, adOe, adIn;
  logic [3:0] regionSelectN, lastSel;
  logic readStrobeN, lowByteWriteStrobeN, highByteWriteStrobeN;
  logic writeEnableN, addrLatchStrobe, burstAddrAdvanceN, burstBusClock;
  logic burstWaitN, hiSeen = 1'b0, bclkSeen = 1'b0, holdWait = 1'b0;
  logic baaSeen = 1'b0;
  logic [15:0] q;
  int failures = 0, n_checks = 0, cycles = 0, strbCnt = 0, weCnt = 0;

  always #2 sys_clk = ~sys_clk;
  always #7.5 linkClk = ~linkClk; // Unrelated phase to sys_clk

  emb_ext_mem_bus dut (.sys_clk, .nrst, .clkEn, .cfg, .gpioOut, .gpioOe,
    .gpioIn, .reqValid, .reqReady, .reqRegion, .reqAddr, .reqWrite,
    .reqByteEn, .reqWdata, .rspValid, .rspRdata, .linkClk, .regionSelectN,
    .readStrobeN, .lowByteWriteStrobeN, .highByteWriteStrobeN,
    .writeEnableN, .addrLatchStrobe, .burstAddrAdvanceN, .burstBusClock,
    .burstWaitN, .extAddr, .adOut, .adOe, .adIn);
  emb_mem_model mem (.linkClk, .selN(regionSelectN), .rdN(readStrobeN),
    .wrLN(lowByteWriteStrobeN), .wrHN(highByteWriteStrobeN),
    .weN(writeEnableN), .beMode(cfg.byteEnMode),
    .ale(addrLatchStrobe), .alePol(cfg.alePolHigh), .mux(cfg.muxMode),
    .extAddr, .adOut, .adOe, .holdWait, .adIn, .burstWaitN);

  // Strobe length and select seen on the far side
  always @(posedge linkClk) begin
    if (!readStrobeN || !lowByteWriteStrobeN) begin
      strbCnt++;
      lastSel = regionSelectN;
    end
    if (!highByteWriteStrobeN) hiSeen = 1'b1;
    if (burstBusClock) bclkSeen = 1'b1;
    if (!writeEnableN) weCnt++;
    if (!burstAddrAdvanceN) baaSeen = 1'b1;
  end

  // Cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Mode change between accesses only
  task automatic set_cfg(logic en, logic w16, logic mx, logic pol,
                         logic bst);
    @(posedge sys_clk);
    #1;
    cfg.busEn = en;
    cfg.wide16 = w16;
    cfg.muxMode = mx;
    cfg.alePolHigh = pol;
    cfg.burstEn = bst;
    cfg.byteEnMode = 1'b0;
    cfg.pageEn = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cfg.rdWait[i] = 4'(i + 1);
      cfg.wrWait[i] = 4'(i + 2);
    end
  endtask : set_cfg

  // One request, held until taken, then wait for the answer
  task automatic access(logic [1:0] r, logic [23:0] a, logic w,
                        logic [1:0] be, logic [15:0] d);
    int n;
    n = 0;
    strbCnt = 0;
    hiSeen = 1'b0;
    bclkSeen = 1'b0;
    weCnt = 0;
    baaSeen = 1'b0;
    @(posedge sys_clk);
    #1;
    {reqRegion, reqAddr, reqWrite, reqByteEn, reqWdata} = {r, a, w, be, d};
    reqValid = 1'b1;
    while (reqReady !== 1'b1) @(posedge sys_clk) #1;
    @(posedge sys_clk);
    #1;
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("answer", 1, n < 3000);
    q = rspRdata;
  endtask : access

  task automatic t_mux16();
    set_cfg(1, 1, 1, 1, 0);
    for (int r = 0; r < 4; r++) begin
      access(2'(r), {2'(r), 22'h2A_5C00} | 24'(r), 1, 2'b11, 16'h1111 * r);
      check("wr len", r + 5, strbCnt);
      check("sel", 4'(~(4'b0001 << r)), lastSel);
      check("hi addr", {2'(r), 6'h2A}, extAddr[23:16]);
    end
    for (int r = 0; r < 4; r++) begin
      access(2'(r), {2'(r), 22'h2A_5C00} | 24'(r), 0, 2'b11, 16'h0000);
      check("rd data", 16'h1111 * r, q);
      check("rd len", r + 4, strbCnt);
    end
    access(0, 24'h2A_5C00, 1, 2'b01, 16'hABEE);
    check("hi strobe", 0, hiSeen);
    access(0, 24'h2A_5C00, 0, 2'b11, 16'h0000);
    check("byte merge", 16'h00EE, q);
    $display("test mux16 done");
  endtask : t_mux16

  task automatic t_mux8();
    set_cfg(1, 0, 1, 0, 0);
    access(1, 24'h5A_3C09, 1, 2'b01, 16'hBEEF);
    check("mid latch", 8'h3C, mem.latA[15:8]);
    check("top port", 8'h5A, extAddr[23:16]);
    check("hi strobe", 0, hiSeen);
    access(1, 24'h5A_3C09, 0, 2'b01, 16'h0000);
    check("rd8", 16'h00EF, q);
    $display("test mux8 done");
  endtask : t_mux8

  task automatic t_burst();
    set_cfg(1, 1, 0, 0, 1);
    access(2, 24'h00_0007, 1, 2'b11, 16'h7E81);
    check("nm wr len", 7, strbCnt);
    holdWait = 1'b1;
    fork
      access(2, 24'h00_0007, 0, 2'b11, 16'h0000);
      begin
        repeat (30) @(posedge linkClk);
        #1 holdWait = 1'b0;
      end
    join
    check("stretch", 1, strbCnt > 10);
    check("nm rd", 16'h7E81, q);
    check("bus clk", 1, bclkSeen);
    check("advance", 1, baaSeen);
    $display("test burst done");
  endtask : t_burst

  // Byte enables with write enable, and a page hit in one region
  task automatic t_nonmux();
    set_cfg(1, 1, 0, 1, 0);
    cfg.byteEnMode = 1'b1;
    cfg.pageEn = 1'b1;
    access(1, 24'h12_3450, 1, 2'b10, 16'hC3A5);
    check("we len", 6, weCnt);
    check("lo strobe", 0, strbCnt);
    repeat (3) @(posedge linkClk);
    #1;
    check("page sel", 4'hD, regionSelectN);
    access(1, 24'h12_3450, 0, 2'b11, 16'h0000);
    check("be rd", 16'hC3EE, q);
    check("be rd len", 5, strbCnt);
    $display("test nonmux done");
  endtask : t_nonmux

  task automatic t_gpio();
    set_cfg(0, 1, 1, 1, 0);
    gpioOut = 16'h5A3C;
    gpioOe = 16'hFFFF;
    repeat (10) @(posedge linkClk);
    #1;
    check("gpio out", 16'h5A3C, adOut);
    check("gpio oe", 16'hFFFF, adOe);
    check("gpio in", 16'h5A3C, gpioIn);
    access(3, 24'h00_0001, 0, 2'b11, 16'h0000);
    check("off rd", 16'h0000, q);
    check("off strb", 0, strbCnt);
    $display("test gpio done");
  endtask : t_gpio

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 nrst = 1'b1;
    t_mux16();
    t_mux8();
    t_nonmux();
    t_burst();
    t_gpio();
    print_verdict();
  end
endmodule : tb
